// >>> rtl/tmon_pkg.sv
// Types shared by the thermal warning monitor.
// Assumes the power-state sequencer drives the state on pclk.
package tmon_pkg;

  // Power state of the device as seen by the monitor
  typedef enum logic [1:0] {
    TMON_PWR_OFF,
    TMON_PWR_ON,
    TMON_PWR_SLEEP,
    TMON_PWR_OTHER
  } tmon_pwr_t;

  // Software configuration of the warning comparator
  typedef struct packed {
    logic hyst_sel;
    logic [1:0] thr_sel;
  } tmon_cfg_t;

endpackage

// >>> rtl/tmon_regs.svh
// Register map and constants of the thermal warning monitor.
// Assumes an APB slave with 32-bit data, one register to a word,
// the byte address being four times the register index.
// Function
// - Monitoring always active in ON and SLEEP
// - Two-bit threshold select, 90 to 120 C
// - One-bit hysteresis select, 8 or 16 C
// - Warning held until at or below threshold minus hysteresis
// - Live warning at status bit 15
// - Event flag set when warning becomes active
// - Event flag also set when warning clears
// - Shutdown in ON or SLEEP requests system reset
// - Event flag cleared only by writing one
// - Unmasked event flag drives thermal interrupt
// - Mask bit 1, resets to masked
`ifndef TMON_REGS_SVH
`define TMON_REGS_SVH

// Register indices
`define TMON_IDX_CFG 16'h4002
`define TMON_IDX_STS 16'h400D
`define TMON_IDX_INT 16'h4011
`define TMON_IDX_MSK 16'h4019
`define TMON_IDX_CLR 16'h4020

// Field positions
`define TMON_CFG_HYST_BIT 3
`define TMON_STS_WARN_BIT 15
`define TMON_INT_WARN_BIT 1

// Reset values
`define TMON_CFG_THR_RST 2'h2
`define TMON_CFG_HYST_RST 1'h1
`define TMON_MSK_RST 1'h1

// Temperatures in degrees C
`define TMON_THR_90 8'h5A
`define TMON_THR_100 8'h64
`define TMON_THR_110 8'h6E
`define TMON_THR_120 8'h78
`define TMON_HYST_8 8'h08
`define TMON_HYST_16 8'h10

`endif

// >>> rtl/tmon_top.sv
// Thermal warning monitor: APB registers, warning comparator with
// hysteresis, two-edge warning event, interrupt and shutdown reset.
// Assumes die temperature and shutdown comparator arrive
// asynchronously from the analogue side; power state on pclk.
//
// Local design decision: the APB register port.
`include "tmon_regs.svh"

module tmon_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] die_temp_c,
  input wire logic shutdown_cmp,
  input wire tmon_pkg::tmon_pwr_t pwr_state,
  output logic overtemp_warning_flag,
  output logic temp_irq,
  output logic sys_reset_req
);
  import tmon_pkg::*;

  // Register storage
  tmon_cfg_t cfg_reg; // Threshold and hysteresis selects
  logic thermal_warn_event_mask_reg; // Mask, 1 blocks interrupt
  logic thermal_warn_event_reg; // Sticky warning event
  logic warn_reg; // Live warning condition
  logic [31:0] prdata_reg; // Read data captured in setup
  logic sys_reset_req_reg; // One-cycle reset request

  // Synchronisers for the analogue side
  logic [7:0] temp_s1_reg; // First stage, read by second only
  logic [7:0] temp_s2_reg; // Second stage
  logic [7:0] temp_s3_reg; // Copy for stability check
  logic [7:0] temp_ok_reg; // Last stable temperature
  logic sd_s1_reg; // Shutdown first stage
  logic sd_s2_reg; // Shutdown second stage
  logic sd_act_d_reg; // Previous gated shutdown level

  // Address decode, index is byte address over four
  wire [15:0] reg_idx = paddr[17:2];
  wire hit_cfg = (reg_idx == `TMON_IDX_CFG);
  wire hit_sts = (reg_idx == `TMON_IDX_STS);
  wire hit_int = (reg_idx == `TMON_IDX_INT);
  wire hit_msk = (reg_idx == `TMON_IDX_MSK);
  wire hit_clr = (reg_idx == `TMON_IDX_CLR);
  wire hit_any = hit_cfg | hit_sts | hit_int | hit_msk | hit_clr;
  wire aligned = (paddr[1:0] == 2'h0);
  wire mapped = hit_any & aligned;

  // Bus phases
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_acc = access_ph & pwrite & mapped;
  wire wr_cfg = wr_acc & hit_cfg;
  wire wr_msk = wr_acc & hit_msk;
  // Clear by W1C on the interrupt register or by the clear alias
  wire clr_hit = wr_acc & (hit_int | hit_clr);
  wire clr_event = clr_hit & pwdata[`TMON_INT_WARN_BIT];

  // Monitoring runs in ON and SLEEP without any enable
  wire mon_active = (pwr_state == TMON_PWR_ON) |
                    (pwr_state == TMON_PWR_SLEEP);

  // Selected warning threshold
  logic [7:0] thr_c;
  always_comb begin
    unique case (cfg_reg.thr_sel)
      2'h0: thr_c = `TMON_THR_90;
      2'h1: thr_c = `TMON_THR_100;
      2'h2: thr_c = `TMON_THR_110;
      2'h3: thr_c = `TMON_THR_120;
    endcase
  end

  // Selected hysteresis margin
  wire [7:0] hyst_c = cfg_reg.hyst_sel ? `TMON_HYST_16
                                      : `TMON_HYST_8;
  // Release point, thresholds exceed the margin so no wrap
  wire [7:0] release_c = thr_c - hyst_c;

  // Warning comparator with hysteresis
  wire temp_hot = (temp_ok_reg >= thr_c);
  wire temp_cool = (temp_ok_reg <= release_c);
  logic warn_next;
  always_comb begin
    if (!mon_active) begin
      // Outside ON and SLEEP nothing is monitored
      warn_next = 1'b0;
    end else if (!warn_reg) begin
      // Enter on reaching the threshold
      warn_next = temp_hot;
    end else begin
      // Hold until fallen by the full margin
      warn_next = ~temp_cool;
    end
  end

  // Both edges of the warning raise the event
  wire warn_rise = warn_next & ~warn_reg;
  wire warn_fall = ~warn_next & warn_reg;
  wire warn_edge = warn_rise | warn_fall;

  // Sticky event, a new edge wins over a clear
  wire event_next = warn_edge |
                    (thermal_warn_event_reg & ~clr_event);

  // Shutdown seen only in ON or SLEEP
  wire sd_act = sd_s2_reg & mon_active;
  wire sd_rise = sd_act & ~sd_act_d_reg;

  // Temperature passes only when two samples agree
  wire temp_stable = (temp_s2_reg == temp_s3_reg);

  // Read multiplexer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux[`TMON_CFG_HYST_BIT] = cfg_reg.hyst_sel;
      rd_mux[1:0] = cfg_reg.thr_sel;
    end else if (hit_sts) begin
      rd_mux[`TMON_STS_WARN_BIT] = warn_reg;
    end else if (hit_int) begin
      rd_mux[`TMON_INT_WARN_BIT] = thermal_warn_event_reg;
    end else if (hit_msk) begin
      rd_mux[`TMON_INT_WARN_BIT] = thermal_warn_event_mask_reg;
    end else begin
      // Clear alias and unmapped addresses read zero
      rd_mux = 32'h0000_0000;
    end
  end

  // Analogue temperature synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_s1_reg <= 8'h00;
      temp_s2_reg <= 8'h00;
      temp_s3_reg <= 8'h00;
    end else begin
      temp_s1_reg <= die_temp_c;
      temp_s2_reg <= temp_s1_reg;
      temp_s3_reg <= temp_s2_reg;
    end
  end

  // Stable temperature used by the comparator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_ok_reg <= 8'h00;
    end else if (temp_stable) begin
      temp_ok_reg <= temp_s3_reg;
    end
  end

  // Shutdown comparator synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_s1_reg <= 1'b0;
      sd_s2_reg <= 1'b0;
      sd_act_d_reg <= 1'b0;
    end else begin
      sd_s1_reg <= shutdown_cmp;
      sd_s2_reg <= sd_s1_reg;
      sd_act_d_reg <= sd_act;
    end
  end

  // System reset request, one pulse per shutdown entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_req_reg <= 1'b0;
    end else begin
      sys_reset_req_reg <= sd_rise;
    end
  end

  // Warning state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_reg <= 1'b0;
    end else begin
      warn_reg <= warn_next;
    end
  end

  // Sticky thermal warning event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_warn_event_reg <= 1'b0;
    end else begin
      thermal_warn_event_reg <= event_next;
    end
  end

  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.thr_sel <= `TMON_CFG_THR_RST;
      cfg_reg.hyst_sel <= `TMON_CFG_HYST_RST;
    end else if (wr_cfg) begin
      cfg_reg.thr_sel <= pwdata[1:0];
      cfg_reg.hyst_sel <= pwdata[`TMON_CFG_HYST_BIT];
    end
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_warn_event_mask_reg <= `TMON_MSK_RST;
    end else if (wr_msk) begin
      thermal_warn_event_mask_reg <=
        pwdata[`TMON_INT_WARN_BIT];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      // Misaligned or unmapped reads return zero
      prdata_reg <= mapped ? rd_mux : 32'h0000_0000;
    end
  end

  // Zero-wait slave, error on unmapped or misaligned access
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_reg;

  // Block outputs
  assign overtemp_warning_flag = warn_reg;
  assign temp_irq = thermal_warn_event_reg &
                    ~thermal_warn_event_mask_reg;
  assign sys_reset_req = sys_reset_req_reg;

endmodule

// >>> testbench/tmon_monitor.sv
// Port checker of the thermal warning monitor.
// Assumes it is bound to tmon_top and sees only its ports.
module tmon_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] die_temp_c,
  input wire logic shutdown_cmp,
  input wire tmon_pkg::tmon_pwr_t pwr_state,
  input wire logic overtemp_warning_flag,
  input wire logic temp_irq,
  input wire logic sys_reset_req
);
  import tmon_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any completed APB write
  wire logic wr_acc = psel && penable && pwrite;
  // Clean rise of the shutdown comparator while ON
  sequence sd_rise;
    (!shutdown_cmp)[*3] ##1 (shutdown_cmp && pwr_state == TMON_PWR_ON)[*3];
  endsequence
  // Die held above every threshold while ON
  sequence hot;
    (die_temp_c == 8'h7D && pwr_state == TMON_PWR_ON)[*8];
  endsequence
  // Die held below every release point
  sequence cold;
    (die_temp_c == 8'h14)[*8];
  endsequence
  a_warn_hot: assert property (hot |-> overtemp_warning_flag)
    else $error("warning missing when hot");
  a_warn_cold: assert property (cold |-> !overtemp_warning_flag)
    else $error("warning stuck when cold");
  a_warn_off: assert property ((pwr_state == TMON_PWR_OFF)[*2] |->
    !overtemp_warning_flag)
    else $error("warning outside ON or SLEEP");
  a_sd_cause: assert property (sd_rise |-> ##[0:2] sys_reset_req)
    else $error("no reset request on shutdown");
  a_sd_single: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  a_sd_state: assert property (sys_reset_req |-> $past(pwr_state) ==
    TMON_PWR_ON || $past(pwr_state) == TMON_PWR_SLEEP)
    else $error("reset request outside ON or SLEEP");
  a_irq_hold: assert property (temp_irq && !wr_acc |=> temp_irq)
    else $error("interrupt dropped without a write");
  a_irq_cause: assert property ($rose(temp_irq) |->
    $changed(overtemp_warning_flag) || $past(wr_acc))
    else $error("interrupt rose without cause");
endmodule

bind tmon_top tmon_monitor tmon_monitor_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .die_temp_c, .shutdown_cmp, .pwr_state, .overtemp_warning_flag,
  .temp_irq, .sys_reset_req);

// >>> testbench/tmon_top_tb.sv
// Self-checking bench of the thermal warning monitor.
// Assumes tmon_top with APB byte address four times the index.
`include "tmon_regs.svh"

module tmon_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmon_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, shutdown_cmp = 1'h0, perr;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, q;
  logic [7:0] die_temp_c = 8'h14, thr, hy;
  tmon_pwr_t pwr_state = TMON_PWR_ON;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, overtemp_warning_flag, temp_irq, sys_reset_req;
  int error_cnt = 0, n_checks = 0, pulses = 0;

  always #5 pclk = ~pclk;
  // Counts shutdown reset requests
  always @(posedge pclk) if (sys_reset_req === 1'h1) pulses++;

  tmon_top tmon_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .die_temp_c,
    .shutdown_cmp, .pwr_state, .overtemp_warning_flag, .temp_irq,
    .sys_reset_req);

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer; held until pready is seen high
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin error_cnt++; tally_and_finish(); end
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    xfer(1'h0, i, 32'h0);
    chk(q, e);
    chk(perr, 1'h0);
  endtask

  task automatic tick(input int k); repeat (k) @(posedge pclk); endtask

  // Bounded wait for the warning level
  task automatic settle(input logic v);
    int n = 0;
    while (overtemp_warning_flag !== v && n < 20) begin tick(1); n++; end
    if (n >= 20) begin error_cnt++; tally_and_finish(); end
  endtask

  initial begin
    tick(3);
    presetn <= 1'h1;
    rd(`TMON_IDX_CFG, 32'hA);
    rd(`TMON_IDX_STS, 32'h0);
    rd(`TMON_IDX_MSK, 32'h2);
    rd(`TMON_IDX_INT, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      thr = 8'h5A + 8'(8'h0A * i);
      hy = i[0] ? 8'h10 : 8'h08;
      xfer(1'h1, `TMON_IDX_CFG, {28'h0, i[0], 1'h0, i[1:0]});
      die_temp_c <= thr - 8'h01;
      tick(10);
      chk(overtemp_warning_flag, 1'h0);
      die_temp_c <= thr;
      settle(1'h1);
      rd(`TMON_IDX_STS, 32'h8000);
      rd(`TMON_IDX_INT, 32'h2);
      xfer(1'h1, `TMON_IDX_INT, 32'h0);
      rd(`TMON_IDX_INT, 32'h2);
      xfer(1'h1, `TMON_IDX_INT, 32'h2);
      rd(`TMON_IDX_INT, 32'h0);
      die_temp_c <= thr - hy + 8'h01;
      tick(10);
      chk(overtemp_warning_flag, 1'h1);
      die_temp_c <= thr - hy;
      settle(1'h0);
      rd(`TMON_IDX_INT, 32'h2);
      xfer(1'h1, `TMON_IDX_INT, 32'h2);
    end
    $display("test thresholds done");
    xfer(1'h1, `TMON_IDX_MSK, 32'h0);
    die_temp_c <= 8'h7D;
    settle(1'h1);
    tick(10);
    chk(temp_irq, 1'h1);
    xfer(1'h1, `TMON_IDX_MSK, 32'h2);
    tick(1);
    chk(temp_irq, 1'h0);
    xfer(1'h1, `TMON_IDX_MSK, 32'h0);
    tick(1);
    chk(temp_irq, 1'h1);
    xfer(1'h1, `TMON_IDX_CLR, 32'h2);
    tick(1);
    chk(temp_irq, 1'h0);
    xfer(1'h0, 16'h4003, 32'h0);
    chk(perr, 1'h1);
    $display("test interrupt done");
    pwr_state <= TMON_PWR_OFF;
    settle(1'h0);
    shutdown_cmp <= 1'h1;
    tick(8);
    chk(pulses, 0);
    shutdown_cmp <= 1'h0;
    die_temp_c <= 8'h14;
    tick(4);
    pwr_state <= TMON_PWR_ON;
    tick(4);
    shutdown_cmp <= 1'h1;
    tick(8);
    chk(pulses, 1);
    shutdown_cmp <= 1'h0;
    pwr_state <= TMON_PWR_SLEEP;
    tick(4);
    shutdown_cmp <= 1'h1;
    tick(8);
    chk(pulses, 2);
    $display("test shutdown done");
    tally_and_finish();
  end
endmodule
